// [verilog/rcd_top.sv]
// Reference clock divider: control register, base clock choice, divider and output pin.
// Assumes a 200 MHz clk, an asynchronous primary oscillator pin far slower than clk / 2,
// and a sleep level from logic on the same clock.
//
// Overview of operation
// - The output enable bit 15 drives the divided clock onto the pin; clear means the clock is off.
// - Bit 14 always reads zero and writes to it have no effect.
// - With the sleep-run bit 13 set the clock keeps running in Sleep, otherwise it stops.
// - With source select bit 12 set the primary oscillator is the base clock.
// - With source select clear the system clock is the base clock and follows its switches.
// - Bits 11 to 8 hold the divisor and code 1111 divides by 32768.
// - Code 1100 divides the base clock by 4096.
// - Code 1011 divides the base clock by 2048.
// - Code 1010 divides the base clock by 1024.
// - Code 1000 divides the base clock by 256.
// - Code 0111 divides the base clock by 128.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rcd_top (
  // Clock, reset and freeze.
  input  wire  logic                       clk,
  input  wire  logic                       rst_n,
  input  wire  logic                       ce,
  // Register port.
  input  wire  logic [rcd_pkg::ADDR_W-1:0] reg_addr,
  input  wire  logic [rcd_pkg::DATA_W-1:0] reg_wdata,
  input  wire  logic                       reg_wr,
  input  wire  logic                       reg_rd,
  output var   logic [rcd_pkg::DATA_W-1:0] reg_rdata,
  // Chip state and oscillator.
  input  wire  logic                       sleep_mode,
  input  wire  logic                       primary_osc_in,
  // Reference clock pin.
  output var   logic                       refclk_output_pin
);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [rcd_pkg::DATA_W-1:0] ctrl_reg;
  logic                       refclk_out_enable;
  logic                       refclk_sleep_run;
  logic                       refclk_source_select;
  logic [rcd_pkg::SEL_W-1:0]  refclk_divisor_select;
  logic                       ctrl_wr;

  assign ctrl_wr = reg_wr && (reg_addr == rcd_pkg::CTRL_ADDR);

  // Hold only the implemented bits; bit 14 and the low byte stay zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rcd_pkg::CTRL_RESET;
    end else if (ce && ctrl_wr) begin
      ctrl_reg <= reg_wdata & rcd_pkg::CTRL_WMASK;
    end
  end

  // Field decode.
  assign refclk_out_enable     = ctrl_reg[rcd_pkg::OUT_EN_BIT];
  assign refclk_sleep_run      = ctrl_reg[rcd_pkg::SLEEP_RUN_BIT];
  assign refclk_source_select  = ctrl_reg[rcd_pkg::SRC_SEL_BIT];
  assign refclk_divisor_select = ctrl_reg[rcd_pkg::DIV_MSB:rcd_pkg::DIV_LSB];

  // ****************************************************************
  // Base clock selection
  // ****************************************************************
  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  logic osc_rise;
  logic base_tick;
  logic running;
  logic div_out;
  logic out_level;

  // Two-stage synchroniser plus an edge history stage for the oscillator pin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else if (ce) begin
      osc_meta_reg <= primary_osc_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  assign osc_rise = osc_sync_reg && !osc_prev_reg;

  // The system clock is clk itself, so every cycle is a base edge and a clock switch
  // upstream is followed automatically.
  assign base_tick = refclk_source_select ? osc_rise : 1'b1;

  // The divider runs while enabled, and in Sleep only when asked to keep running.
  assign running = refclk_out_enable && (!sleep_mode || refclk_sleep_run);

  rcd_divider u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .clear   (!running),
    .tick    (base_tick),
    .sel     (refclk_divisor_select),
    .div_out (div_out)
  );

  // Code zero on the oscillator passes its level straight through.
  assign out_level = (refclk_source_select && (refclk_divisor_select == rcd_pkg::CODE_PASS))
                   ? osc_sync_reg : div_out;

  // ****************************************************************
  // Output pin and read port
  // ****************************************************************
  // The pin is registered, so it goes low in the cycle after the reference clock goes off and stays low while it is off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refclk_output_pin <= 1'b0;
    end else if (ce) begin
      refclk_output_pin <= running && out_level;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= rcd_pkg::DATA_ZERO;
    end else if (ce) begin
      reg_rdata <= rcd_pkg::DATA_ZERO;
      if (reg_rd && (reg_addr == rcd_pkg::CTRL_ADDR)) begin
        reg_rdata <= ctrl_reg;
      end else if (reg_rd && (reg_addr == rcd_pkg::STAT_ADDR)) begin
        reg_rdata[rcd_pkg::STAT_LEVEL_BIT] <= refclk_output_pin;
        reg_rdata[rcd_pkg::STAT_RUN_BIT]   <= running;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper: cycles between toggles of the divider output under a settled setup.
  logic        div_prev_reg;
  logic        div_tog;
  logic [15:0] gap_reg;
  logic        gap_ok_reg;
  logic [15:0] gap_len;

  assign div_tog = div_out != div_prev_reg;
  assign gap_len = gap_reg + rcd_pkg::ONE_CNT;

  // Measure the half period seen on the divider output.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_prev_reg <= 1'b0;
      gap_reg      <= '0;
      gap_ok_reg   <= 1'b0;
    end else if (ce) begin
      div_prev_reg <= div_out;
      gap_reg      <= div_tog ? '0 : gap_len;
      if (ctrl_wr || !running) begin
        gap_ok_reg <= 1'b0;
      end else if (div_tog) begin
        gap_ok_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A settled half period on the system clock.
  sequence s_sys_half;
    ce && div_tog && gap_ok_reg && !refclk_source_select;
  endsequence

  // A read strobe of the control register; its data follow in the next cycle.
  sequence s_ctrl_read;
    ce && reg_rd && (reg_addr == rcd_pkg::CTRL_ADDR);
  endsequence

  property p_off_low;
    (ce && !refclk_out_enable) |=> !refclk_output_pin;
  endproperty
  a_off_low: assert property (p_off_low) else $error("Pin active while disabled.");

  property p_bit14_zero;
    s_ctrl_read |=> !reg_rdata[rcd_pkg::RSVD_BIT];
  endproperty
  a_bit14_zero: assert property (p_bit14_zero) else $error("Bit 14 read as one.");

  property p_sleep_stop;
    (ce && sleep_mode && !refclk_sleep_run) |=> !refclk_output_pin;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("Clock ran in Sleep.");

  property p_osc_hold;
    (ce && refclk_source_select && !osc_rise && running && !ctrl_wr) |=> $stable(div_out);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("Divider moved without oscillator edge.");

  property p_sys_tick;
    (ce && !refclk_source_select && running && !ctrl_wr
      && (refclk_divisor_select == rcd_pkg::CODE_PASS)) ##1 ce |-> div_tog;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("System clock tick missed.");

  property p_ratio(logic [3:0] code, int ratio);
    s_sys_half and (refclk_divisor_select == code) |-> gap_len == 16'(ratio / 2);
  endproperty
  a_ratio_max: assert property (p_ratio(rcd_pkg::CODE_MAX, rcd_pkg::RATIO_MAX))
    else $error("Wrong period for code 1111.");
  a_ratio_4096: assert property (p_ratio(rcd_pkg::CODE_4096, rcd_pkg::RATIO_4096))
    else $error("Wrong period for code 1100.");
  a_ratio_2048: assert property (p_ratio(rcd_pkg::CODE_2048, rcd_pkg::RATIO_2048))
    else $error("Wrong period for code 1011.");
  a_ratio_1024: assert property (p_ratio(rcd_pkg::CODE_1024, rcd_pkg::RATIO_1024))
    else $error("Wrong period for code 1010.");
  a_ratio_256: assert property (p_ratio(rcd_pkg::CODE_256, rcd_pkg::RATIO_256))
    else $error("Wrong period for code 1000.");
  a_ratio_128: assert property (p_ratio(rcd_pkg::CODE_128, rcd_pkg::RATIO_128))
    else $error("Wrong period for code 0111.");

  property p_ratio_any;
    s_sys_half |-> gap_len == rcd_pkg::half_period(refclk_divisor_select);
  endproperty
  a_ratio_any: assert property (p_ratio_any) else $error("Wrong period for divisor code.");

endmodule : rcd_top
`default_nettype wire

// [verilog/rcd_pkg.sv]
// Constants, register layout and divider helpers for the reference clock divider.
// Assumes a single 200 MHz system clock domain and a plain register port.
package rcd_pkg;

  // ****************************************************************
  // Register port and map
  // ****************************************************************
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 16;
  localparam logic [3:0]  CTRL_ADDR  = 4'h0;
  localparam logic [3:0]  STAT_ADDR  = 4'h1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hbf00;   // Bit 14 and the low byte are not held.
  localparam logic [15:0] DATA_ZERO  = 16'h0000;

  // Control field positions.
  localparam int OUT_EN_BIT    = 15;
  localparam int RSVD_BIT      = 14;
  localparam int SLEEP_RUN_BIT = 13;
  localparam int SRC_SEL_BIT   = 12;
  localparam int DIV_MSB       = 11;
  localparam int DIV_LSB       = 8;

  // Status field positions.
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_RUN_BIT   = 1;

  // ****************************************************************
  // Divider
  // ****************************************************************
  localparam int         SEL_W     = 4;
  localparam int         CNT_W     = 16;
  localparam logic [3:0] CODE_PASS = 4'h0;
  localparam logic [3:0] CODE_MAX  = 4'hf;
  localparam logic [3:0] CODE_4096 = 4'hc;
  localparam logic [3:0] CODE_2048 = 4'hb;
  localparam logic [3:0] CODE_1024 = 4'ha;
  localparam logic [3:0] CODE_256  = 4'h8;
  localparam logic [3:0] CODE_128  = 4'h7;
  localparam int RATIO_MAX  = 32768;
  localparam int RATIO_4096 = 4096;
  localparam int RATIO_2048 = 2048;
  localparam int RATIO_1024 = 1024;
  localparam int RATIO_256  = 256;
  localparam int RATIO_128  = 128;
  localparam logic [15:0] ONE_CNT = 16'h0001;

  // Base ticks per half period of the output for a divisor code.
  function automatic logic [15:0] half_period(input logic [3:0] sel);
    if (sel == CODE_PASS) begin
      return ONE_CNT;
    end
    return ONE_CNT << (sel - 4'h1);
  endfunction : half_period

endpackage : rcd_pkg

// [verilog/rcd_divider.sv]
// Power-of-two tick divider producing a square wave.
// Assumes tick is a same-domain enable marking each base clock edge.
`timescale 1ns/1ps
`default_nettype none
module rcd_divider (
  // Clock, reset and freeze.
  input  wire  logic                      clk,
  input  wire  logic                      rst_n,
  input  wire  logic                      ce,
  // Control.
  input  wire  logic                      clear,
  input  wire  logic                      tick,
  input  wire  logic [rcd_pkg::SEL_W-1:0] sel,
  // Divided output.
  output var   logic                      div_out
);

  logic [rcd_pkg::CNT_W-1:0] cnt_reg;
  logic [rcd_pkg::CNT_W-1:0] limit;

  // Last count of a half period; a lowered divisor also ends the half period.
  assign limit = rcd_pkg::half_period(sel) - rcd_pkg::ONE_CNT;

  // Count base ticks and toggle the output every half period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      div_out <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        cnt_reg <= '0;
        div_out <= 1'b0;
      end else if (tick) begin
        if (cnt_reg >= limit) begin
          cnt_reg <= '0;
          div_out <= ~div_out;
        end else begin
          cnt_reg <= cnt_reg + rcd_pkg::ONE_CNT;
        end
      end
    end
  end

endmodule : rcd_divider
`default_nettype wire

// [sim/rcd_top_tb.sv]
// Self-checking testbench for the reference clock divider top level.
// Assumes rcd_pkg and rcd_top are compiled first; drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module rcd_top_tb;
  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  logic                       clk;
  logic                       rst_n;
  logic                       ce;
  logic [rcd_pkg::ADDR_W-1:0] reg_addr;
  logic [rcd_pkg::DATA_W-1:0] reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [rcd_pkg::DATA_W-1:0] reg_rdata;
  logic                       sleep_mode;
  logic                       primary_osc_in;
  logic                       refclk_output_pin;
  logic [rcd_pkg::DATA_W-1:0] rd_val;
  int                         fail_count;
  int                         checks_done;
  int                         last_n;
  logic [3:0]                 codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'ha, 4'hb,
                                             4'hc, 4'hf};
  int                         ratios [10] = '{2, 2, 4, 8, 128, 256, 1024, 2048, 4096, 32768};

  rcd_top u_dut (
    .clk               (clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .sleep_mode        (sleep_mode),
    .primary_osc_in    (primary_osc_in),
    .refclk_output_pin (refclk_output_pin)
  );

  // The system clock toggles every 2.5 ns, giving a period of 5 ns.
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // The primary oscillator is enabled from reset on, long before any test selects it.
  // It toggles every 4 system cycles, giving a period of 8 cycles.
  int osc_cnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      osc_cnt        <= 0;
      primary_osc_in <= 1'b0;
    end else begin
      osc_cnt <= (osc_cnt + 1) % 4;
      if (osc_cnt == 3) begin
        primary_osc_in <= ~primary_osc_in;
      end
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // One-cycle write strobe with address and data beside it.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data are taken in the cycle after it.
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  // Counts cycles up to the next rising edge of the pin, under a bound.
  task automatic wait_rise();
    logic prev;
    bit   seen;
    prev   = refclk_output_pin;
    seen   = 1'b0;
    last_n = 0;
    while (!seen && last_n < 70000) begin
      @(posedge clk);
      #1;
      last_n++;
      seen = (prev === 1'b0) && (refclk_output_pin === 1'b1);
      prev = refclk_output_pin;
    end
    if (!seen) begin
      fail_count++;
      $display("CHECK FAILED pin_rise expected 1 seen 0");
      finish_test();
    end
  endtask : wait_rise

  // Checks one full output period after the first rising edge.
  task automatic measure(input int exp);
    wait_rise();
    wait_rise();
    `CHK("period", exp, last_n)
  endtask : measure

  // Checks that the pin stays low for a number of cycles.
  task automatic hold_low(input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (refclk_output_pin !== 1'b0) bad++;
    end
    `CHK("pin_low", 0, bad)
  endtask : hold_low

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    fail_count  = 0;
    checks_done = 0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    sleep_mode  = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state: clock off and control cleared.
    rd(4'h0);
    `CHK("ctrl_reset", 16'h0000, rd_val)
    `CHK("pin_reset", 1'b0, refclk_output_pin)
    // Bit 14 and the low byte never hold written ones.
    wr(4'h0, 16'hffff);
    rd(4'h0);
    `CHK("ctrl_mask", 16'hbf00, rd_val)
    rd(4'h1);
    `CHK("stat_running", 1'b1, rd_val[1])
    // Unmapped index reads zero and its write leaves control alone.
    wr(4'h3, 16'h0000);
    rd(4'h3);
    `CHK("unmapped", 16'h0000, rd_val)
    // A write while frozen is ignored.
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h0, 16'h0000);
    ce <= 1'b1;
    rd(4'h0);
    `CHK("ctrl_frozen", 16'hbf00, rd_val)
    // Every tested divisor code on the system clock.
    for (int i = 0; i < 10; i++) begin
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h8000 | {4'h0, codes[i], 8'h00});
      measure(ratios[i]);
    end
    // Enable clear turns the clock off.
    wr(4'h0, 16'h0100);
    repeat (2) @(posedge clk);
    hold_low(20);
    rd(4'h1);
    `CHK("stat_off", 16'h0000, rd_val)
    // Sleep stops the clock unless the sleep-run bit is set.
    wr(4'h0, 16'h8100);
    @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    hold_low(20);
    wr(4'h0, 16'ha100);
    measure(2);
    @(posedge clk);
    sleep_mode <= 1'b0;
    // Primary oscillator as base clock, 8 system cycles per period.
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h9200);
    measure(32);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h9000);
    measure(8);
    finish_test();
  end
endmodule : rcd_top_tb
`default_nettype wire
